// [src/buck_pkg.sv]
// constants, command codes and strap tables for the buck control block
package buck_pkg;
	// command codes seen on the command port
	localparam logic [7:0] CMD_VOUT = 8'h21;
	localparam logic [7:0] CMD_PERIOD = 8'h33;
	localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
	localparam logic [7:0] CMD_OC_RESP = 8'h47;
	localparam logic [7:0] CMD_MODE = 8'hc8;
	localparam logic [7:0] CMD_BASE = 8'hd0;
	localparam logic [7:0] CMD_STATUS = 8'hd1;
	// vendor mode fields
	localparam int MODE_PRESET_DIS_BIT = 0;
	localparam int MODE_SYNC_EN_BIT = 1;
	localparam logic [7:0] MODE_RESET = 8'h00;
	// current limit in amps
	localparam logic [4:0] OC_LIMIT_MIN = 5'h01;
	localparam logic [4:0] OC_LIMIT_RESET = 5'h14;
	localparam logic [8:0] OC130_NUM = 9'h00d;
	localparam logic [8:0] OC130_DEN = 9'h00a;
	// response field layout: delay in ms low, action above
	localparam int RESP_DLY_LSB = 0;
	localparam int RESP_DLY_W = 4;
	localparam int RESP_ACT_LSB = 4;
	localparam logic [3:0] OC_DELAY_MAX_MS = 4'ha;
	localparam logic [7:0] OC_RESP_RESET = 8'h20;
	// fault actions
	typedef enum logic [1:0] {
		ACT_IGNORE = 2'b00,
		ACT_IGNORE_UNDERVOLTAGE_LOCKOUT = 2'b01,
		ACT_HICCUP = 2'b10,
		ACT_LATCH = 2'b11
	} oc_action_t;
	// protection states
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HICCUP = 2'b01,
		ST_LATCHED = 2'b10
	} prot_state_t;
	// switching period in clock cycles
	localparam logic [15:0] PERIOD_RESET = 16'h01a0;
	localparam logic [15:0] PERIOD_MIN = 16'h0071;
	// status bits
	localparam int STAT_LIMITING = 0;
	localparam int STAT_HICCUP = 1;
	localparam int STAT_LATCHED = 2;
	localparam int STAT_OC130 = 3;
	localparam int STAT_STRAPS = 4;
	// strap decode
	localparam logic [3:0] STRAP_SHORT = 4'h0;
	localparam logic [3:0] STRAP_OPEN = 4'hf;
	localparam logic [6:0] ADDR_FIXED = 7'h0f;
	localparam logic [6:0] BASE_DEFAULT = 7'h40;
	localparam logic [12:0] VOUT_DEFAULT_MV = 13'h0258;
	// timing
	localparam int CLK_MHZ = 250;
	localparam int US_PER_MS = 1000;
	localparam int HICCUP_MS = 1000;
	// preset target in millivolts per strap bin
	function automatic logic [12:0] vout_strap_pin_mv(input logic [3:0] bin);
		case (bin)
			4'h0: vout_strap_pin_mv = 13'h0258;
			4'h1: vout_strap_pin_mv = 13'h0258;
			4'h2: vout_strap_pin_mv = 13'h0384;
			4'h3: vout_strap_pin_mv = 13'h03b6;
			4'h4: vout_strap_pin_mv = 13'h03e8;
			4'h5: vout_strap_pin_mv = 13'h041a;
			4'h6: vout_strap_pin_mv = 13'h04b0;
			4'h7: vout_strap_pin_mv = 13'h04e2;
			4'h8: vout_strap_pin_mv = 13'h05dc;
			4'h9: vout_strap_pin_mv = 13'h0708;
			4'ha: vout_strap_pin_mv = 13'h0834;
			4'hb: vout_strap_pin_mv = 13'h09c4;
			4'hc: vout_strap_pin_mv = 13'h0ce4;
			4'hd: vout_strap_pin_mv = 13'h1388;
			default: vout_strap_pin_mv = 13'h0320;
		endcase
	endfunction
endpackage

// [src/buck_ctrl.sv]
// strap decode, switching cycle sequencer and peak overcurrent protection
`timescale 1ns/1ns
module buck_ctrl #(
	parameter int MS_CYCLES = buck_pkg::CLK_MHZ * buck_pkg::US_PER_MS,
	parameter int HICCUP_CYCLES = buck_pkg::HICCUP_MS * MS_CYCLES,
	parameter logic [6:0] BASE_NVM = buck_pkg::BASE_DEFAULT
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// resistor strap bins from the strap converters
	input wire logic [3:0] addr_strap_bin,
	input wire logic [3:0] vout_strap_pin,
	// command port from the bus front end
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata_ff,
	output logic cmd_rvalid_ff,
	// analog comparators and enable
	input wire logic converter_en,
	input wire logic vout_above_300mv,
	input wire logic ramp_trip,
	input wire logic oc_trip,
	input wire logic oc130_trip,
	input wire logic sync_clk,
	// power stage and analog settings
	output logic hs_on_ff,
	output logic ls_on_ff,
	output logic ramp_start_ff,
	output logic [4:0] oc_limit_amps_ff,
	output logic [5:0] oc130_amps_ff,
	output logic [12:0] vout_target_mv_ff,
	output logic [6:0] slave_addr_ff,
	output logic undervoltage_lockout_enable_ff,
	output logic hiccup_ff,
	output logic latched_ff
);
	import buck_pkg::*;

	// register group state
	logic [7:0] mode_ff, nxt_mode;
	logic [7:0] oc_resp_ff, nxt_oc_resp;
	logic [4:0] nxt_oc_limit;
	logic [5:0] nxt_oc130;
	logic [15:0] period_ff, nxt_period;
	logic [12:0] vout_host_ff, nxt_vout_host;
	logic vout_written_ff, nxt_vout_written;
	logic [6:0] base_ff, nxt_base;
	logic [15:0] nxt_rdata;
	logic nxt_rvalid;
	logic oc130_seen_ff, nxt_oc130_seen;
	// strap group state
	logic straps_done_ff, nxt_straps_done;
	logic [3:0] addr_bin_ff, nxt_addr_bin;
	logic [3:0] vout_strap_pin_bin_ff, nxt_vout_strap_pin_bin;
	logic [6:0] nxt_slave_addr;
	logic [12:0] nxt_vout_target;
	// switching group state
	logic [15:0] cnt_ff, nxt_cnt;
	logic sync_prev_ff, nxt_sync_prev;
	logic hs_block_ff, nxt_hs_block;
	logic lim_seen_ff, nxt_lim_seen;
	logic limiting_ff, nxt_limiting;
	logic nxt_hs, nxt_ls, nxt_ramp_start;
	logic period_start;
	logic run_ok;
	// protection group state
	prot_state_t state_ff, nxt_state;
	logic [31:0] oc_timer_ff, nxt_oc_timer;
	logic [31:0] hic_cnt_ff, nxt_hic_cnt;
	logic [31:0] oc_delay_cycles;
	logic nxt_undervoltage_lockout, nxt_hiccup, nxt_latched;
	oc_action_t act;

	assign act = oc_action_t'(oc_resp_ff[RESP_ACT_LSB +: 2]);
	assign oc_delay_cycles = 32'(oc_resp_ff[RESP_DLY_LSB +: RESP_DLY_W]) * 32'(MS_CYCLES);
	assign run_ok = (state_ff == ST_RUN) && converter_en;

	// host commands: limit, delay and period writes clamp to the legal range, reads answer next cycle
	always_comb begin
		nxt_mode = mode_ff;
		nxt_oc_resp = oc_resp_ff;
		nxt_oc_limit = oc_limit_amps_ff;
		nxt_period = period_ff;
		nxt_vout_host = vout_host_ff;
		nxt_vout_written = vout_written_ff;
		nxt_base = base_ff;
		nxt_rdata = cmd_rdata_ff;
		nxt_rvalid = 1'b0;
		nxt_oc130_seen = oc130_seen_ff | oc130_trip;
		if (cmd_wr) begin
			case (cmd_code)
				CMD_MODE: nxt_mode = cmd_wdata[7:0];
				CMD_OC_LIMIT: begin
					// zero is below range, so it becomes the lowest limit
					nxt_oc_limit = (cmd_wdata[4:0] < OC_LIMIT_MIN) ? OC_LIMIT_MIN : cmd_wdata[4:0];
				end
				CMD_OC_RESP: begin
					nxt_oc_resp = cmd_wdata[7:0];
					if (cmd_wdata[RESP_DLY_LSB +: RESP_DLY_W] > OC_DELAY_MAX_MS) begin
						nxt_oc_resp[RESP_DLY_LSB +: RESP_DLY_W] = OC_DELAY_MAX_MS;
					end
				end
				CMD_PERIOD: nxt_period = (cmd_wdata < PERIOD_MIN) ? PERIOD_MIN : cmd_wdata;
				CMD_VOUT: begin
					nxt_vout_host = cmd_wdata[12:0];
					nxt_vout_written = 1'b1;
				end
				CMD_BASE: nxt_base = cmd_wdata[6:0];
				CMD_STATUS: begin
					// write-one-to-clear, a fresh trip in the same cycle wins
					if (cmd_wdata[STAT_OC130] && !oc130_trip) begin
						nxt_oc130_seen = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (cmd_rd) begin
			nxt_rvalid = 1'b1;
			case (cmd_code)
				CMD_MODE: nxt_rdata = {8'h00, mode_ff};
				CMD_OC_LIMIT: nxt_rdata = {11'h000, oc_limit_amps_ff};
				CMD_OC_RESP: nxt_rdata = {8'h00, oc_resp_ff};
				CMD_PERIOD: nxt_rdata = period_ff;
				CMD_VOUT: nxt_rdata = {3'h0, vout_target_mv_ff};
				CMD_BASE: nxt_rdata = {9'h000, base_ff};
				CMD_STATUS: begin
					nxt_rdata = 16'h0000;
					nxt_rdata[STAT_LIMITING] = limiting_ff;
					nxt_rdata[STAT_HICCUP] = hiccup_ff;
					nxt_rdata[STAT_LATCHED] = latched_ff;
					nxt_rdata[STAT_OC130] = oc130_seen_ff;
					nxt_rdata[STAT_STRAPS] = straps_done_ff;
				end
				default: nxt_rdata = 16'h0000;
			endcase
		end
		// second threshold tracks the programmed limit
		nxt_oc130 = 6'(nxt_oc_limit_scaled(nxt_oc_limit));
	end

	// 130% of the limit, rounded down to whole amps
	function automatic logic [8:0] nxt_oc_limit_scaled(input logic [4:0] lim);
		nxt_oc_limit_scaled = 9'({4'h0, lim} * OC130_NUM) / OC130_DEN;
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= MODE_RESET;
			oc_resp_ff <= OC_RESP_RESET;
			oc_limit_amps_ff <= OC_LIMIT_RESET;
			oc130_amps_ff <= 6'h00;
			period_ff <= PERIOD_RESET;
			vout_host_ff <= VOUT_DEFAULT_MV;
			vout_written_ff <= 1'b0;
			base_ff <= BASE_NVM;
			cmd_rdata_ff <= 16'h0000;
			cmd_rvalid_ff <= 1'b0;
			oc130_seen_ff <= 1'b0;
		end else if (clk_en) begin
			mode_ff <= nxt_mode;
			oc_resp_ff <= nxt_oc_resp;
			oc_limit_amps_ff <= nxt_oc_limit;
			oc130_amps_ff <= nxt_oc130;
			period_ff <= nxt_period;
			vout_host_ff <= nxt_vout_host;
			vout_written_ff <= nxt_vout_written;
			base_ff <= nxt_base;
			cmd_rdata_ff <= nxt_rdata;
			cmd_rvalid_ff <= nxt_rvalid;
			oc130_seen_ff <= nxt_oc130_seen;
		end
	end

	// straps caught once on the first enabled edge after release, then frozen
	always_comb begin
		nxt_straps_done = 1'b1;
		nxt_addr_bin = addr_bin_ff;
		nxt_vout_strap_pin_bin = vout_strap_pin_bin_ff;
		if (!straps_done_ff) begin
			nxt_addr_bin = addr_strap_bin;
			nxt_vout_strap_pin_bin = vout_strap_pin;
		end
		// short or open strap cannot be told from a fault, so use the fixed address
		if (addr_bin_ff == STRAP_SHORT || addr_bin_ff == STRAP_OPEN) begin
			nxt_slave_addr = ADDR_FIXED;
		end else begin
			nxt_slave_addr = base_ff + {3'h0, addr_bin_ff - 4'h1};
		end
		if (vout_written_ff || mode_ff[MODE_PRESET_DIS_BIT]) begin
			nxt_vout_target = vout_host_ff;
		end else begin
			nxt_vout_target = vout_strap_pin_mv(vout_strap_pin_bin_ff);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			straps_done_ff <= 1'b0;
			addr_bin_ff <= STRAP_SHORT;
			vout_strap_pin_bin_ff <= STRAP_SHORT;
			slave_addr_ff <= ADDR_FIXED;
			vout_target_mv_ff <= VOUT_DEFAULT_MV;
		end else if (clk_en) begin
			straps_done_ff <= nxt_straps_done;
			addr_bin_ff <= nxt_addr_bin;
			vout_strap_pin_bin_ff <= nxt_vout_strap_pin_bin;
			slave_addr_ff <= nxt_slave_addr;
			vout_target_mv_ff <= nxt_vout_target;
		end
	end

	// period start on counter wrap, or on a sync rising edge when the mode sync enable bit is set
	assign period_start = (cnt_ff >= period_ff - 16'h0001) ||
		(mode_ff[MODE_SYNC_EN_BIT] && sync_clk && !sync_prev_ff);

	// switching cycle sequencer
	always_comb begin
		nxt_cnt = cnt_ff + 16'h0001;
		nxt_sync_prev = sync_clk;
		nxt_hs = hs_on_ff;
		nxt_ls = ls_on_ff;
		nxt_hs_block = hs_block_ff;
		nxt_lim_seen = lim_seen_ff | oc_trip;
		nxt_limiting = limiting_ff;
		nxt_ramp_start = 1'b0;
		if (period_start) begin
			nxt_cnt = 16'h0000;
			nxt_hs = run_ok;
			nxt_ls = 1'b0;
			nxt_ramp_start = run_ok;
			nxt_hs_block = 1'b0;
			// a clean cycle ends the limiting run
			nxt_limiting = lim_seen_ff | oc_trip;
			nxt_lim_seen = 1'b0;
		end else if (oc_trip || hs_block_ff) begin
			nxt_hs = 1'b0;
			nxt_hs_block = 1'b1;
			nxt_ls = run_ok && vout_above_300mv;
		end else if (ramp_trip && hs_on_ff) begin
			nxt_hs = 1'b0;
			nxt_ls = run_ok && vout_above_300mv;
		end
		// faults override everything at once; low output only forces the low side off
		if (!run_ok || oc130_trip) begin
			nxt_hs = 1'b0;
			nxt_ls = 1'b0;
			nxt_ramp_start = 1'b0;
		end else if (!vout_above_300mv) begin
			nxt_ls = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 16'h0000;
			sync_prev_ff <= 1'b0;
			hs_on_ff <= 1'b0;
			ls_on_ff <= 1'b0;
			ramp_start_ff <= 1'b0;
			hs_block_ff <= 1'b0;
			lim_seen_ff <= 1'b0;
			limiting_ff <= 1'b0;
		end else if (clk_en) begin
			cnt_ff <= nxt_cnt;
			sync_prev_ff <= nxt_sync_prev;
			hs_on_ff <= nxt_hs;
			ls_on_ff <= nxt_ls;
			ramp_start_ff <= nxt_ramp_start;
			hs_block_ff <= nxt_hs_block;
			lim_seen_ff <= nxt_lim_seen;
			limiting_ff <= nxt_limiting;
		end
	end

	// protection: duration timer, hiccup wait, latch-off until reset
	always_comb begin
		nxt_state = state_ff;
		nxt_oc_timer = oc_timer_ff;
		nxt_hic_cnt = hic_cnt_ff;
		if (limiting_ff && state_ff == ST_RUN) begin
			if (oc_timer_ff != 32'hffffffff) begin
				nxt_oc_timer = oc_timer_ff + 32'h00000001;
			end
		end else begin
			nxt_oc_timer = 32'h00000000;
		end
		case (state_ff)
			ST_RUN: begin
				nxt_hic_cnt = 32'h00000000;
				if (oc130_trip) begin
					nxt_state = (act == ACT_LATCH) ? ST_LATCHED : ST_HICCUP;
				end else if (limiting_ff && oc_timer_ff >= oc_delay_cycles) begin
					// ignore responses keep running under cycle limit
					if (act == ACT_LATCH) begin
						nxt_state = ST_LATCHED;
					end else if (act == ACT_HICCUP) begin
						nxt_state = ST_HICCUP;
					end
				end
			end
			ST_HICCUP: begin
				nxt_oc_timer = 32'h00000000;
				if (hic_cnt_ff >= 32'(HICCUP_CYCLES) - 32'h00000001) begin
					nxt_state = ST_RUN;
					nxt_hic_cnt = 32'h00000000;
				end else begin
					nxt_hic_cnt = hic_cnt_ff + 32'h00000001;
				end
			end
			ST_LATCHED: nxt_state = ST_LATCHED;
			default: nxt_state = ST_RUN;
		endcase
		nxt_undervoltage_lockout = (act == ACT_IGNORE_UNDERVOLTAGE_LOCKOUT);
		nxt_hiccup = (nxt_state == ST_HICCUP);
		nxt_latched = (nxt_state == ST_LATCHED);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_RUN;
			oc_timer_ff <= 32'h00000000;
			hic_cnt_ff <= 32'h00000000;
			undervoltage_lockout_enable_ff <= 1'b0;
			hiccup_ff <= 1'b0;
			latched_ff <= 1'b0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			oc_timer_ff <= nxt_oc_timer;
			hic_cnt_ff <= nxt_hic_cnt;
			undervoltage_lockout_enable_ff <= nxt_undervoltage_lockout;
			hiccup_ff <= nxt_hiccup;
			latched_ff <= nxt_latched;
		end
	end
endmodule

// [verification/buck_ctrl_assertions.sv]
// port-level checks for the buck control block
`timescale 1ns/1ns
module buck_ctrl_chk
	import buck_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// command port
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_rdata_ff,
	input wire logic cmd_rvalid_ff,
	// comparators
	input wire logic vout_above_300mv,
	input wire logic ramp_trip,
	input wire logic oc_trip,
	input wire logic oc130_trip,
	// power stage and settings
	input wire logic hs_on_ff,
	input wire logic ls_on_ff,
	input wire logic ramp_start_ff,
	input wire logic [4:0] oc_limit_amps_ff,
	input wire logic [5:0] oc130_amps_ff,
	input wire logic [6:0] slave_addr_ff,
	input wire logic hiccup_ff,
	input wire logic latched_ff
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// gate drive ties back to its causes
	AST_LS_NEEDS_VOUT: assert property (ls_on_ff |-> $past(vout_above_300mv))
		else $error("low side on with output low");
	AST_HS_ONLY_AT_START: assert property ($rose(hs_on_ff) |-> ramp_start_ff)
		else $error("high side rose outside period start");
	AST_RAMP_TRIP_OFF: assert property (hs_on_ff && ramp_trip && clk_en |=> !hs_on_ff || ramp_start_ff)
		else $error("high side kept on after ramp trip");
	AST_OC_BLANK: assert property (hs_on_ff && oc_trip && clk_en |=> !hs_on_ff || ramp_start_ff)
		else $error("high side kept on after limit trip");
	AST_OC130_STOP: assert property (oc130_trip && clk_en |=> !hs_on_ff && !ls_on_ff)
		else $error("switching went on after high trip");
	// the high threshold is 13/10 of the limit, floor
	AST_OC130_SCALE: assert property ($past(rst_n, 2) && $stable(oc_limit_amps_ff)
		|-> oc130_amps_ff == 6'(9'(oc_limit_amps_ff) * OC130_NUM / OC130_DEN))
		else $error("high threshold not 130 percent");
	AST_LATCH_HOLD: assert property (latched_ff |=> latched_ff && !hs_on_ff && !hiccup_ff)
		else $error("latch-off left or switching");
	AST_LIMIT_READ: assert property (cmd_rd && clk_en && cmd_code == CMD_OC_LIMIT
		|=> cmd_rvalid_ff && cmd_rdata_ff == {11'h000, $past(oc_limit_amps_ff)})
		else $error("limit read wrong");
	// strap bin is caught once; later strap moves must not show
	AST_STRAPS_HELD: assert property ($past(rst_n, 4) && !$past(cmd_wr) && !$past(cmd_wr, 2)
		|-> $stable(slave_addr_ff))
		else $error("address moved after capture");
	COV_START: cover property (ramp_start_ff && hs_on_ff);
	COV_LATCH: cover property ($rose(latched_ff));
	COV_HICCUP_END: cover property ($fell(hiccup_ff));
endmodule

bind buck_ctrl buck_ctrl_chk chk (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .cmd_wr(cmd_wr),
	.cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_rdata_ff(cmd_rdata_ff), .cmd_rvalid_ff(cmd_rvalid_ff),
	.vout_above_300mv(vout_above_300mv), .ramp_trip(ramp_trip), .oc_trip(oc_trip),
	.oc130_trip(oc130_trip), .hs_on_ff(hs_on_ff), .ls_on_ff(ls_on_ff), .ramp_start_ff(ramp_start_ff),
	.oc_limit_amps_ff(oc_limit_amps_ff), .oc130_amps_ff(oc130_amps_ff), .slave_addr_ff(slave_addr_ff),
	.hiccup_ff(hiccup_ff), .latched_ff(latched_ff));

// [verification/pmbus_host_model.sv]
// host side model driving the command port
`timescale 1ns/1ns
module pmbus_host_model (
	// clock
	input wire logic clock,
	// command port toward the block
	output logic cmd_wr,
	output logic cmd_rd,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata_ff,
	input wire logic cmd_rvalid_ff
);
	// quiet port at time zero
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// one write; host sets mode, limit, delay, action, period, target voltage, base or status clear
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		@(negedge clock);
		cmd_code = code;
		cmd_wdata = data;
		cmd_wr = 1'b1;
		@(negedge clock);
		cmd_wr = 1'b0;
		// released lines carry junk, not the last word
		cmd_code = ~code;
		cmd_wdata = ~data;
	endtask
	// one read; answer taken while valid stands, bounded wait
	task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
		int n;
		ok = 1'b0;
		data = 16'h0000;
		@(negedge clock);
		cmd_code = code;
		cmd_rd = 1'b1;
		@(negedge clock);
		cmd_rd = 1'b0;
		cmd_code = ~code;
		for (n = 0; n < 4 && !ok; n++) begin
			if (cmd_rvalid_ff === 1'b1) begin
				ok = 1'b1;
				data = cmd_rdata_ff;
			end else begin
				@(negedge clock);
			end
		end
	endtask
endmodule

// [verification/test_buck_strap_config_and_ocp.sv]
// self-checking bench for straps, switching and overcurrent handling
`timescale 1ns/1ns
module test_buck_strap_config_and_ocp;
	import buck_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] addr_strap_bin = 4'h5;
	logic [3:0] vout_strap_pin = 4'hc;
	logic converter_en = 1'b0;
	logic vout_above_300mv = 1'b1;
	logic ramp_trip = 1'b0;
	logic oc_trip = 1'b0;
	logic oc130_trip = 1'b0;
	logic sync_clk = 1'b0;
	logic cmd_wr;
	logic cmd_rd;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata;
	logic [15:0] cmd_rdata_ff;
	logic cmd_rvalid_ff;
	logic hs_on_ff;
	logic ls_on_ff;
	logic ramp_start_ff;
	logic [4:0] oc_limit_amps_ff;
	logic [5:0] oc130_amps_ff;
	logic [12:0] vout_target_mv_ff;
	logic [6:0] slave_addr_ff;
	logic undervoltage_lockout_enable_ff;
	logic hiccup_ff;
	logic latched_ff;
	int mismatches = 0;
	int checks_done = 0;
	int i;
	logic [15:0] rd_val;
	logic rd_ok;
	// strap bins and the address and millivolts they must give
	logic [3:0] a_bin [4] = '{4'h0, 4'h1, 4'he, 4'hf};
	logic [6:0] a_exp [4] = '{7'h0f, 7'h40, 7'h4d, 7'h0f};
	logic [3:0] v_bin [4] = '{4'h0, 4'h1, 4'hd, 4'he};
	logic [12:0] v_exp [4] = '{13'h0258, 13'h0258, 13'h1388, 13'h0320};

	always #2 clock = ~clock;

	// short counts keep hiccup and delay runs brief
	buck_ctrl #(.MS_CYCLES(10), .HICCUP_CYCLES(50)) dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.addr_strap_bin(addr_strap_bin), .vout_strap_pin(vout_strap_pin), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata_ff(cmd_rdata_ff), .cmd_rvalid_ff(cmd_rvalid_ff),
		.converter_en(converter_en), .vout_above_300mv(vout_above_300mv), .ramp_trip(ramp_trip),
		.oc_trip(oc_trip), .oc130_trip(oc130_trip), .sync_clk(sync_clk), .hs_on_ff(hs_on_ff),
		.ls_on_ff(ls_on_ff), .ramp_start_ff(ramp_start_ff), .oc_limit_amps_ff(oc_limit_amps_ff),
		.oc130_amps_ff(oc130_amps_ff), .vout_target_mv_ff(vout_target_mv_ff), .slave_addr_ff(slave_addr_ff),
		.undervoltage_lockout_enable_ff(undervoltage_lockout_enable_ff), .hiccup_ff(hiccup_ff), .latched_ff(latched_ff));

	pmbus_host_model hst (.clock(clock), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .cmd_rdata_ff(cmd_rdata_ff), .cmd_rvalid_ff(cmd_rvalid_ff));

	task automatic give_verdict();
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// read a command and compare; a missing answer also fails
	task automatic reg_chk(input logic [7:0] code, input logic [15:0] exp);
		hst.rd(code, rd_val, rd_ok);
		check_val({15'h0000, rd_ok}, 16'h0001);
		check_val(rd_val, exp);
	endtask
	// bounded wait on start, latched or hiccup reaching a level
	task automatic wait_on(input int sel, input logic lvl, input int lim);
		int n;
		logic s;
		s = 1'b0;
		for (n = 0; n < lim; n++) begin
			@(negedge clock);
			s = sel == 0 ? ramp_start_ff : (sel == 1 ? latched_ff : hiccup_ff);
			if (s === lvl) begin
				return;
			end
		end
		check_val({15'h0000, s}, {15'h0000, lvl});
		give_verdict();
	endtask
	// one-cycle comparator or sync pulse: 0 ramp, 1 limit, 2 high limit, 3 sync
	task automatic pulse(input int sel);
		@(negedge clock);
		{sync_clk, oc130_trip, oc_trip, ramp_trip} = 4'h1 << sel;
		@(negedge clock);
		{sync_clk, oc130_trip, oc_trip, ramp_trip} = 4'h0;
	endtask
	task automatic do_reset();
		@(negedge clock);
		rst_n = 1'b0;
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
	endtask

	initial begin
		do_reset();
		// every strap corner decoded after a fresh reset
		for (i = 0; i < 4; i++) begin
			addr_strap_bin = a_bin[i];
			vout_strap_pin = v_bin[i];
			do_reset();
			check_val(16'(slave_addr_ff), 16'(a_exp[i]));
			check_val(16'(vout_target_mv_ff), 16'(v_exp[i]));
		end
		addr_strap_bin = 4'h1;
		repeat (5) @(negedge clock);
		check_val(16'(slave_addr_ff), 16'h000f);
		reg_chk(CMD_MODE, 16'h0000);
		hst.wr(CMD_MODE, 16'h0001);
		reg_chk(CMD_MODE, 16'h0001);
		check_val(16'(vout_target_mv_ff), 16'(VOUT_DEFAULT_MV));
		// preset back on, so the host write must win over the strap
		hst.wr(CMD_MODE, 16'h0000);
		hst.wr(CMD_VOUT, 16'h03e8);
		repeat (3) @(negedge clock);
		check_val(16'(vout_target_mv_ff), 16'h03e8);
		// limit floor and top, with the derived high threshold
		reg_chk(CMD_OC_LIMIT, 16'h0014);
		hst.wr(CMD_OC_LIMIT, 16'h0000);
		reg_chk(CMD_OC_LIMIT, 16'h0001);
		hst.wr(CMD_OC_LIMIT, 16'h001f);
		reg_chk(CMD_OC_LIMIT, 16'h001f);
		check_val(16'(oc130_amps_ff), 16'h0028);
		check_val(16'(oc_limit_amps_ff), 16'h001f);
		// a frozen clock enable must drop the write
		clk_en = 1'b0;
		hst.wr(CMD_OC_LIMIT, 16'h0005);
		clk_en = 1'b1;
		reg_chk(CMD_OC_LIMIT, 16'h001f);
		hst.wr(CMD_OC_RESP, 16'h000f);
		reg_chk(CMD_OC_RESP, 16'h000a);
		// walk all four actions, ending on plain ignore
		for (i = 3; i >= 0; i--) begin
			hst.wr(CMD_OC_RESP, 16'(i << 4));
			repeat (2) @(negedge clock);
			check_val(16'(undervoltage_lockout_enable_ff), 16'(i == 1));
		end
		// period from the host, measured start to start
		hst.wr(CMD_PERIOD, 16'h0071);
		converter_en = 1'b1;
		wait_on(0, 1'b1, 500);
		check_val(16'(hs_on_ff), 16'h0001);
		for (i = 1; i < 200; i++) begin
			@(negedge clock);
			if (ramp_start_ff === 1'b1) begin
				break;
			end
		end
		check_val(16'(i), 16'h0071);
		hst.wr(CMD_MODE, 16'h0002);
		repeat (20) @(negedge clock);
		pulse(3);
		check_val(16'(ramp_start_ff), 16'h0001);
		wait_on(0, 1'b1, 200);
		pulse(0);
		check_val(16'({hs_on_ff, ls_on_ff}), 16'h0001);
		// low output keeps the low side off after a ramp trip
		wait_on(0, 1'b1, 200);
		vout_above_300mv = 1'b0;
		pulse(0);
		check_val(16'({hs_on_ff, ls_on_ff}), 16'h0000);
		vout_above_300mv = 1'b1;
		wait_on(0, 1'b1, 200);
		pulse(1);
		repeat (20) @(negedge clock);
		check_val(16'({hs_on_ff, ls_on_ff}), 16'h0001);
		// limit held every cycle for 1 ms of delay gives latch-off
		hst.wr(CMD_OC_RESP, 16'h0031);
		oc_trip = 1'b1;
		wait_on(1, 1'b1, 400);
		repeat (2) @(negedge clock);
		check_val(16'({hs_on_ff, ls_on_ff}), 16'h0000);
		oc_trip = 1'b0;
		do_reset();
		// reprogrammed base moves the address, strap offset 0
		hst.wr(CMD_BASE, 16'h0050);
		repeat (2) @(negedge clock);
		check_val(16'(slave_addr_ff), 16'h0050);
		// high trip under hiccup, then under latch-off
		pulse(2);
		check_val(16'({hs_on_ff, ls_on_ff}), 16'h0000);
		wait_on(2, 1'b1, 3);
		// status: hiccup, sticky high trip, straps; then clear the sticky bit
		reg_chk(CMD_STATUS, 16'h001a);
		hst.wr(CMD_STATUS, 16'h0008);
		reg_chk(CMD_STATUS, 16'h0012);
		wait_on(2, 1'b0, 80);
		hst.wr(CMD_OC_RESP, 16'h0030);
		pulse(2);
		wait_on(1, 1'b1, 3);
		give_verdict();
	end
endmodule
